// >>> hw/igr_map.svh
`ifndef IGR_MAP_SVH
`define IGR_MAP_SVH

// ----------------------------------------------------------------
// serial link constants
// ----------------------------------------------------------------
`define IGR_SLAVE_ADDR     7'h59
`define IGR_BYTE_BITS      4'h8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IGR_OFS_DIR_CTRL   8'h06
`define IGR_OFS_PIN_LEVEL  8'h07

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IGR_PIN_COUNT      3
`define IGR_DIR_MSB        2
`define IGR_PWM_SEL_BIT    4
`define IGR_LEVEL_MSB      2
`define IGR_DIR_RESET      3'h0
`define IGR_PWM_RESET      1'h0
`define IGR_LEVEL_RESET    3'h0

`endif

// >>> hw/igr_pkg.sv
`include "igr_map.svh"

package igr_pkg;

  // ----------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IGR_IDLE,      // bus free, after stop or reset
    IGR_ADDR,      // receiving address byte
    IGR_ADDR_ACK,  // acknowledging address
    IGR_REG,       // receiving register index
    IGR_REG_ACK,   // acknowledging index
    IGR_DATA,      // receiving write data
    IGR_DATA_ACK,  // acknowledging data
    IGR_RD,        // shifting out read byte
    IGR_RD_ACK,    // sampling master acknowledge
    IGR_SKIP       // wait for stop or start
  } igr_state_e;

  // ----------------------------------------------------------------
  // complete state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      scl_s1;     // first sync stage
    logic                      scl_s2;     // second sync stage
    logic                      scl_d;      // delayed for edges
    logic                      sda_s1;
    logic                      sda_s2;
    logic                      sda_d;
    logic                      rst_s1;     // external reset sync
    logic                      rst_s2;
    logic [`IGR_PIN_COUNT-1:0] gpio_s1;    // pin level sync
    logic [`IGR_PIN_COUNT-1:0] gpio_s2;
    igr_state_e                fsm;        // serial engine state
    logic [3:0]                bit_cnt;    // bits in current byte
    logic [7:0]                shift;      // rx/tx shift register
    logic                      rd_dir;     // read transfer
    logic [7:0]                reg_idx;    // selected register
    logic                      more;       // master acked read
    logic [`IGR_PIN_COUNT-1:0] dir;        // direction bits
    logic                      pwm_sel;    // pin 0 as pwm input
    logic [`IGR_PIN_COUNT-1:0] level;      // written pin levels
    logic                      sda_oe;     // pulling data low
    logic                      sda_lvl;    // data drive level
    logic [`IGR_PIN_COUNT-1:0] gpio_oe;    // pin drive enables
    logic [`IGR_PIN_COUNT-1:0] gpio_lvl;   // pin drive levels
    logic                      pwm_led_on; // led activation level
  } igr_state_s;

endpackage

// >>> hw/igr_gpio_regs.sv

`include "igr_map.svh"

module igr_gpio_regs (
  input  wire logic                      clk_sys_in,            // 40 mhz system clock
  input  wire logic                      srst_in,               // sync reset, high
  input  wire logic                      external_reset_n_in,   // pin reset, low
  input  wire logic                      scl_in,                // serial clock pin
  input  wire logic                      sda_in,                // serial data pin level
  output logic                           sda_out,               // data drive level
  output logic                           sda_oe_out,            // data pulled low
  input  wire logic [`IGR_PIN_COUNT-1:0] gpio_in,               // pin levels
  output logic      [`IGR_PIN_COUNT-1:0] gpio_out,              // pin drive levels
  output logic      [`IGR_PIN_COUNT-1:0] gpio_oe_out,           // pin drive enables
  output logic                           pwm_led_on_out         // led activation
);

  import igr_pkg::*;

  // ----------------------------------------------------------------
  // state and edge terms
  // ----------------------------------------------------------------
  igr_state_s st;        // registered state
  igr_state_s next_st;   // next state
  logic       scl_rise;  // clock rising edge
  logic       scl_fall;  // clock falling edge
  logic       start_det; // start or repeated start
  logic       stop_det;  // stop condition
  logic [7:0] rd_byte;   // register read mux

  // edges seen on second sync stage only
  assign scl_rise  = st.scl_s2 & ~st.scl_d;
  assign scl_fall  = ~st.scl_s2 & st.scl_d;
  // data edges while clock held high
  assign start_det = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
  assign stop_det  = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (st.reg_idx)
      `IGR_OFS_DIR_CTRL: begin
        rd_byte[`IGR_DIR_MSB:0]    = st.dir;
        rd_byte[`IGR_PWM_SEL_BIT]  = st.pwm_sel;
      end
      `IGR_OFS_PIN_LEVEL: begin
        // live sampled pin levels, whatever the direction
        rd_byte[`IGR_LEVEL_MSB:0]  = st.gpio_s2;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // synchronisers, serial engine, registers and pin drive
  always_comb begin
    next_st = st;

    // two-stage sync of every outside input but srst_in
    next_st.scl_s1  = scl_in;
    next_st.scl_s2  = st.scl_s1;
    next_st.scl_d   = st.scl_s2;
    next_st.sda_s1  = sda_in;
    next_st.sda_s2  = st.sda_s1;
    next_st.sda_d   = st.sda_s2;
    next_st.rst_s1  = external_reset_n_in;
    next_st.rst_s2  = st.rst_s1;
    next_st.gpio_s1 = gpio_in;
    next_st.gpio_s2 = st.gpio_s1;

    // data line is never driven high
    next_st.sda_lvl = 1'b0;

    if (stop_det) begin
      // bus free again: release and go idle
      next_st.fsm    = IGR_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (start_det) begin
      // first and repeated start alike
      next_st.fsm     = IGR_ADDR;
      next_st.bit_cnt = 4'h0;
      next_st.sda_oe  = 1'b0;
    end else begin
      unique case (st.fsm)
        IGR_IDLE, IGR_SKIP: begin
          // wait for the master's next start
          next_st.sda_oe = 1'b0;
        end
        IGR_ADDR, IGR_REG, IGR_DATA: begin
          if (scl_rise) begin
            // sample on rising edge, msb first
            next_st.shift   = {st.shift[6:0], st.sda_s2};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall && st.bit_cnt == `IGR_BYTE_BITS) begin
            // byte complete: pull low for ack in the ninth clock
            next_st.bit_cnt = 4'h0;
            next_st.sda_oe  = 1'b1;
            if (st.fsm == IGR_ADDR) begin
              // address in upper seven, direction in lsb
              if (st.shift[7:1] == `IGR_SLAVE_ADDR) begin
                next_st.rd_dir = st.shift[0];
                next_st.fsm    = IGR_ADDR_ACK;
              end else begin
                // not ours: stay silent
                next_st.sda_oe = 1'b0;
                next_st.fsm    = IGR_SKIP;
              end
            end else if (st.fsm == IGR_REG) begin
              // second byte chooses the register
              next_st.reg_idx = st.shift;
              next_st.fsm     = IGR_REG_ACK;
            end else begin
              // data byte held in shift until the ack edge
              next_st.fsm = IGR_DATA_ACK;
            end
          end
        end
        IGR_ADDR_ACK, IGR_REG_ACK, IGR_DATA_ACK: begin
          if (scl_rise && st.fsm == IGR_DATA_ACK) begin
            // write lands on the rising edge of each data ack
            unique case (st.reg_idx)
              `IGR_OFS_DIR_CTRL: begin
                next_st.dir     = st.shift[`IGR_DIR_MSB:0];
                next_st.pwm_sel = st.shift[`IGR_PWM_SEL_BIT];
              end
              `IGR_OFS_PIN_LEVEL: begin
                next_st.level = st.shift[`IGR_LEVEL_MSB:0];
              end
              default: begin
                // unknown index: write dropped, still acked
                next_st.level = st.level;
              end
            endcase
          end else if (scl_fall) begin
            // ack over: release line on the low phase
            next_st.sda_oe  = 1'b0;
            next_st.bit_cnt = 4'h0;
            if (st.fsm == IGR_ADDR_ACK && st.rd_dir) begin
              // read: first bit goes out right away
              next_st.shift  = rd_byte;
              next_st.sda_oe = ~rd_byte[7];
              next_st.fsm    = IGR_RD;
            end else if (st.fsm == IGR_ADDR_ACK) begin
              next_st.fsm = IGR_REG;
            end else begin
              // further bytes rewrite the same register
              next_st.fsm = IGR_DATA;
            end
          end
        end
        IGR_RD: begin
          if (scl_rise) begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bit_cnt == `IGR_BYTE_BITS) begin
              // release for the master's ack bit
              next_st.sda_oe = 1'b0;
              next_st.fsm    = IGR_RD_ACK;
            end else begin
              // next bit placed while clock low
              next_st.shift  = {st.shift[6:0], 1'b0};
              next_st.sda_oe = ~st.shift[6];
            end
          end
        end
        IGR_RD_ACK: begin
          if (scl_rise) begin
            // low means the master wants another byte
            next_st.more = ~st.sda_s2;
          end else if (scl_fall) begin
            next_st.bit_cnt = 4'h0;
            if (st.more) begin
              // repeat the same register
              next_st.shift  = rd_byte;
              next_st.sda_oe = ~rd_byte[7];
              next_st.fsm    = IGR_RD;
            end else begin
              // no ack: wait for stop
              next_st.fsm = IGR_SKIP;
            end
          end
        end
        default: begin
          // illegal code: recover to idle
          next_st.fsm    = IGR_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end

    // external reset pin overrides engine and registers, but not the syncs, shift, rd_dir or reg_idx
    if (!st.rst_s2) begin
      next_st.fsm     = IGR_IDLE;
      next_st.bit_cnt = 4'h0;
      next_st.sda_oe  = 1'b0;
      next_st.dir     = `IGR_DIR_RESET;
      next_st.pwm_sel = `IGR_PWM_RESET;
      next_st.level   = `IGR_LEVEL_RESET;
      next_st.more    = 1'b0;
    end

    // pin drive: pwm select forces pin 0 to input
    next_st.gpio_oe    = next_st.dir;
    if (next_st.pwm_sel) begin
      next_st.gpio_oe[0] = 1'b0;
    end
    next_st.gpio_lvl   = next_st.level;
    // led activation follows the pwm pin when selected
    next_st.pwm_led_on = next_st.pwm_sel & st.gpio_s2[0];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // sync reset loads constants only
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st        <= '0;
      st.rst_s1 <= 1'b1;
      st.rst_s2 <= 1'b1;
      st.fsm    <= IGR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from state flops
  // ----------------------------------------------------------------
  assign sda_out        = st.sda_lvl;
  assign sda_oe_out     = st.sda_oe;
  assign gpio_out       = st.gpio_lvl;
  assign gpio_oe_out    = st.gpio_oe;
  assign pwm_led_on_out = st.pwm_led_on;

endmodule

// >>> bench/igr_gpio_regs_asserts.sv
// ----------------------------------------------------------------
// port checker for the register slave
// ----------------------------------------------------------------
module igr_gpio_regs_asserts (
  input wire logic       clk_sys_in,
  input wire logic       srst_in,
  input wire logic       external_reset_n_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [2:0] gpio_in,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe_out,
  input wire logic       pwm_led_on_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // data line is only ever pulled low
  a_drive_low_only: assert property (!sda_out)
    else $error("data line driven high");
  // data drive moves only while the serial clock is low
  a_change_clk_low: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
    else $error("data drive changed with clock high");
  // pin setup changes only after an acknowledge clock rise
  a_reg_at_ack: assert property ($changed({gpio_oe_out, gpio_out}) && external_reset_n_in
    |-> $past(scl_in, 3)) else $error("pin setup changed off an ack edge");
  // pwm role keeps pin 0 from being driven
  a_pin0_pwm_input: assert property (pwm_led_on_out && $past(pwm_led_on_out)
    |-> !gpio_oe_out[0]) else $error("pin 0 driven while pwm input");
  // leds come on only after pin 0 was high
  a_led_needs_pin: assert property ($rose(pwm_led_on_out)
    |-> $past(gpio_in[0], 2) || $past(gpio_in[0], 3) || $past(gpio_in[0], 4))
    else $error("leds on without high pwm pin");
  // a low pwm pin keeps leds off
  a_led_off_low: assert property (!$past(gpio_in[0], 2) && !$past(gpio_in[0], 3)
    && !$past(gpio_in[0], 4) |-> !pwm_led_on_out) else $error("leds on with low pwm pin");
  // outputs quiet right after synchronous reset
  a_reset_quiet: assert property ($past(srst_in) |-> !sda_oe_out && gpio_oe_out == 3'h0
    && gpio_out == 3'h0 && !pwm_led_on_out) else $error("outputs active after reset");
  // pin reset leaves every pin an input
  a_ext_clear: assert property (!external_reset_n_in [*6] |-> gpio_oe_out == 3'h0
    && !sda_oe_out) else $error("pins driven during pin reset");
endmodule

bind igr_gpio_regs igr_gpio_regs_asserts igr_gpio_regs_asserts_i (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .external_reset_n_in(external_reset_n_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
  .pwm_led_on_out(pwm_led_on_out));

// >>> bench/igr_master_model.sv
// ----------------------------------------------------------------
// two-wire bus master, open drain with pull-up
// ----------------------------------------------------------------
module igr_master_model (
  input  wire logic clk_sys_in,    // system clock for pacing
  input  wire logic sda_oe_in,     // device pulls data low
  input  wire logic sda_lvl_in,    // device drive level, open drain
  output logic      scl_out,       // serial clock, high at idle
  output logic      sda_wire_out   // resolved data wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sda_low = 1'b0;      // master pulls data low
  logic [8:0] res;                 // ack flag and read byte
  event       got;                 // one result per transfer
  initial scl_out = 1'b1;
  // pull-up gives the high level when nobody pulls
  // a device drive of one cannot lift the wire: only a low level pulls it
  assign sda_wire_out = !sda_low && !(sda_oe_in && !sda_lvl_in);
  // wait n clocks, change just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // start, also usable as repeated start
  task automatic start();
    step(2);
    sda_low = 1'b0;
    step(2);
    scl_out = 1'b1;
    step(4);
    sda_low = 1'b1;
    step(4);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    step(2);
    sda_low = 1'b1;
    step(2);
    scl_out = 1'b1;
    step(4);
    sda_low = 1'b0;
    step(4);
  endtask
  // one clock: data moves mid low phase, sampled at end of high
  task automatic bitx(input logic b, output logic r);
    step(2);
    sda_low = !b;
    step(2);
    scl_out = 1'b1;
    step(4);
    r = sda_wire_out;
    scl_out = 1'b0;
  endtask
  // eight bits msb first, then released ninth clock
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // read byte, then withhold acknowledge
  task automatic rd_byte(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      v[i] = r;
    end
    bitx(1'b1, r);
  endtask
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] val);
    logic a0, a1, a2;
    start();
    wr_byte(8'hb2, a0);
    wr_byte(idx, a1);
    wr_byte(val, a2);
    stop();
    res = {a0 & a1 & a2, 8'h00};
    -> got;
  endtask
  task automatic reg_read(input logic [7:0] idx);
    logic a0, a1, a2;
    logic [7:0] v;
    start();
    wr_byte(8'hb2, a0);
    wr_byte(idx, a1);
    start();
    wr_byte(8'hb3, a2);
    rd_byte(v);
    stop();
    res = {a0 & a1 & a2, v};
    -> got;
  endtask
  // address byte alone, then stop
  task automatic probe(input logic [7:0] adr);
    logic a0;
    start();
    wr_byte(adr, a0);
    stop();
    res = {a0, 8'h00};
    -> got;
  endtask
endmodule

// >>> bench/igr_gpio_regs_bench.sv
module igr_gpio_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic        ext_rst_n  = 1'b1;   // pin reset, active low
  logic        scl, sda, sda_drv, sda_oe, led;
  logic [2:0]  ext_pins   = 3'h0;   // level of outside pin drivers
  logic [2:0]  gpio_out, gpio_oe, pins, oe_e;
  logic [31:0] seed       = 32'd65736;
  logic [8:0]  exp_q[$];            // expected transfer results
  int          err_count  = 0;
  int          total_checks = 0;
  initial forever #12.5 clk_sys_in = !clk_sys_in;
  // pins resolve between device drive and outside level
  assign pins = (gpio_oe & gpio_out) | (~gpio_oe & ext_pins);
  igr_gpio_regs igr_gpio_regs_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .external_reset_n_in(ext_rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .gpio_in(pins), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe),
    .pwm_led_on_out(led));
  igr_master_model igr_master_model_i (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe),
    .sda_lvl_in(sda_drv), .scl_out(scl), .sda_wire_out(sda));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    exp_q.push_back(9'h100);
    igr_master_model_i.reg_write(idx, val);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] val);
    exp_q.push_back({1'b1, val});
    igr_master_model_i.reg_read(idx);
  endtask
  // result watcher: oldest note against each finished transfer
  always @(igr_master_model_i.got) check(igr_master_model_i.res, exp_q.pop_front());
  // watchdog cuts a hang short
  initial begin
    #600us;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    igr_master_model_i.step(4);
    rd(8'h06, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      repeat (8) seed = lfsr_next(seed);
      seed[4] = k[0];
      ext_pins = seed[14:12];
      oe_e = seed[2:0] & ~{2'b00, seed[4]};
      wr(8'h06, seed[7:0]);
      wr(8'h07, seed[15:8]);
      check({6'h0, gpio_oe}, {6'h0, oe_e});
      check({6'h0, gpio_out}, {6'h0, seed[10:8]});
      check({8'h0, led}, {8'h0, seed[4] & ext_pins[0]});
      rd(8'h06, {3'h0, seed[4], 1'b0, seed[2:0]});
      rd(8'h07, {5'h0, (oe_e & seed[10:8]) | (~oe_e & ext_pins)});
      $display("pin setup test %0d done", k);
    end
    exp_q.push_back(9'h000);
    igr_master_model_i.probe(8'hb0);
    $display("foreign address test done");
    // unmapped index: write acked and dropped, read gives zero
    wr(8'h05, seed[23:16]);
    rd(8'h05, 8'h00);
    $display("unmapped index test done");
    // pin reset taken from a fully driven setup
    wr(8'h06, 8'h07);
    wr(8'h07, 8'h07);
    check({6'h0, gpio_oe}, 9'h007);
    check({6'h0, gpio_out}, 9'h007);
    ext_rst_n = 1'b0;
    igr_master_model_i.step(8);
    check({6'h0, gpio_oe}, 9'h000);
    check({6'h0, gpio_out}, 9'h000);
    ext_rst_n = 1'b1;
    igr_master_model_i.step(4);
    rd(8'h06, 8'h00);
    rd(8'h07, {5'h0, ext_pins});
    $display("pin reset test done");
    // synchronous reset in mid-run, pwm role and direction bits 0 and 1 set
    wr(8'h06, 8'h13);
    check({6'h0, gpio_oe}, 9'h002);
    srst_in = 1'b1;
    igr_master_model_i.step(2);
    srst_in = 1'b0;
    igr_master_model_i.step(4);
    check({6'h0, gpio_oe}, 9'h000);
    rd(8'h06, 8'h00);
    $display("sync reset test done");
    igr_master_model_i.step(2);
    complete_run();
  end
endmodule
